/* core/spc_pkg.sv */
// Constants, register map and state encoding of the stop-mode controller.
// Assumes a byte-wide register port with a four-bit address.

package spc_pkg;

	// ------------------------------------------------------------
	// Register port
	// ------------------------------------------------------------
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;

	localparam logic [3:0] POWER_MODE_OFS   = 4'h0;
	localparam logic [3:0] VOLT_DETECT_OFS  = 4'h1;
	localparam logic [3:0] OPTION_OFS       = 4'h2;
	localparam logic [3:0] STATUS_OFS       = 4'h3;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int PWR_DOWN_BIT     = 0;
	localparam int PART_DOWN_BIT    = 1;
	localparam int LATCH_ACK_BIT    = 2;
	localparam int PART_FLAG_BIT    = 3;
	localparam int LVD_ENABLE_BIT   = 0;
	localparam int LVD_IN_STOP_BIT  = 1;
	localparam int STOP_ALLOW_BIT   = 0;
	localparam int DEBUG_ALLOW_BIT  = 1;
	localparam int RATE_LSB         = 2;
	localparam int RATE_MSB         = 4;
	localparam int STAT_VEC_LSB     = 3;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic       CTRL_BIT_RST = 1'b0;
	localparam logic [2:0] RATE_OFF     = 3'h0;
	localparam logic [7:0] READ_ZERO    = 8'h00;

	// ------------------------------------------------------------
	// Wake vectors taken from stop3
	// ------------------------------------------------------------
	localparam logic [1:0] VEC_NONE = 2'h0;
	localparam logic [1:0] VEC_IRQ  = 2'h1;
	localparam logic [1:0] VEC_KBD  = 2'h2;
	localparam logic [1:0] VEC_TMR  = 2'h3;

	typedef enum logic [2:0] {
		ST_RUN   = 3'b000,
		ST_STOP1 = 3'b001,
		ST_STOP2 = 3'b010,
		ST_STOP3 = 3'b011,
		ST_REARM = 3'b100
	} spc_state_e;

endpackage : spc_pkg

/* core/spc_wake_if.sv */
// Synchronised wake events passed from the wake synchroniser to the
// controller. Assumes both ends share one clock.

`timescale 1ns/1ps
`default_nettype none

interface spc_wake_if;
	logic resetReq;
	logic irqLevel;
	logic kbiAny;
	logic rtiEvt;
	logic bgndEvt;

	modport src (output resetReq, irqLevel, kbiAny, rtiEvt, bgndEvt);
	modport dst (input  resetReq, irqLevel, kbiAny, rtiEvt, bgndEvt);
endinterface : spc_wake_if

`default_nettype wire

/* core/spc_wake_sync.sv */
// Two-stage synchroniser for wake pins and wake-timer ticks.
// Assumes the always-on clock keeps running while system clocks halt.

`timescale 1ns/1ps
`default_nettype none

module spc_wake_sync (
	input  wire logic       clock,
	input  wire logic       rstn,
	input  wire logic       resetPinN,
	input  wire logic       irqPin,
	input  wire logic [7:0] kbiPins,
	input  wire logic [7:0] kbiEnable,
	input  wire logic       rtiTick,
	input  wire logic       bgndCmd,
	spc_wake_if.src         wake
);

	logic [4:0] rawWake;
	logic [4:0] syncA_r;
	logic [4:0] syncB_r;
	logic [4:0] syncC_r;

	// Keyboard pins wake when any enabled pin is pulled low
	assign rawWake = {bgndCmd, rtiTick, |(~kbiPins & kbiEnable), irqPin,
		~resetPinN};

	// ------------------------------------------------------------
	// Synchroniser and edge stage
	// ------------------------------------------------------------
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			syncA_r <= 5'h00;
			syncB_r <= 5'h00;
			syncC_r <= 5'h00;
		end else begin
			syncA_r <= rawWake;
			syncB_r <= syncA_r;
			syncC_r <= syncB_r;
		end
	end

	assign wake.resetReq = syncB_r[0];
	assign wake.irqLevel = syncB_r[1];
	assign wake.kbiAny   = syncB_r[2];
	assign wake.rtiEvt   = syncB_r[3] & ~syncC_r[3];
	assign wake.bgndEvt  = syncB_r[4] & ~syncC_r[4];

endmodule : spc_wake_sync

`default_nettype wire

/* core/spc_stop_ctrl.sv */
// Stop-mode power controller: mode entry, power controls, pin latches,
// wake-up and recovery. Assumes a CPU that pulses stopExec for one cycle
// and an always-on clock for this block.
//
// The strobed register port and the register addresses were decided locally.

`timescale 1ns/1ps
`default_nettype none

//Contract
//- Stop instruction with stop allowed enters a stop mode, halting clocks.
//- Stop instruction without stop allowed forces illegal-opcode reset instead.
//- Power-down 1/partial 0 stop1; 1/1 stop2; power-down 0 stop3.
//- Stop1 or stop2 only when low-voltage detection not enabled in stop.
//- Stop1 powers down core and RAM, standby, pins reset, timer off.
//- Stop1 wakes only on reset or interrupt pin, interrupt active low.
//- Stop1 asserts low voltage; exit waits for rearm, then power-on restart.
//- Stop2 powers down all but RAM, regulator and converter standby.
//- Stop2 entry latches pins until software acknowledges with a 1.
//- Stop2 wakes on reset pin, active-low interrupt pin or timer.
//- Stop2 wake restarts as power-on, pin latches stay closed.
//- Stop2 wake sets partial power-down flag until acknowledged.
//- Released latches let pins follow port registers or peripherals.
//- Stop3 halts all clocks and oscillator, keeps state, converter off; the code puts the converter in standby.
//- Stop3 exits by reset pin to reset, or by interrupt vectors.
//- Rate select zero disables wake timer; no timer wake then.
//- Debug allowed at entry keeps debug clocks, oscillator, full regulation.
//- Stop1 or stop2 request with debug allowed enters stop3.
//- In stop, status memory commands error; background command wakes.
//- Low-voltage detect in stop keeps regulator; stop1/2 become stop3.
module spc_stop_ctrl (
	input  wire logic       clock,
	input  wire logic       rstn,
	input  wire logic [3:0] regAddr,
	input  wire logic [7:0] regWdata,
	input  wire logic       regWrite,
	input  wire logic       regRead,
	output logic      [7:0] regRdata,
	input  wire logic       stopExec,
	input  wire logic       resetPinN,
	input  wire logic       irqPin,
	input  wire logic       irqActiveHigh,
	input  wire logic [7:0] kbiPins,
	input  wire logic [7:0] kbiEnable,
	input  wire logic       rtiTick,
	input  wire logic       bgndCmd,
	input  wire logic       memStatusCmd,
	input  wire logic       supplyRearm,
	output logic            sysClockHalt,
	output logic            oscRun,
	output logic            debugClockRun,
	output logic            regulatorStandby,
	output logic            converterStandby,
	output logic            corePowerOn,
	output logic            ramPowerOn,
	output logic            pinForceReset,
	output logic            pinLatchHold,
	output logic            wakeTimerOn,
	output logic            lowVoltageAssert,
	output logic            illegalOpReset,
	output logic            porRestart,
	output logic            intWake,
	output logic      [1:0] intVector,
	output logic            debugWake,
	output logic            debugStopError,
	output logic            memAccessBlock
);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic regHit(input logic [3:0] addr,
		input logic [3:0] ofs, input logic stb);
		regHit = stb && (addr == ofs);
	endfunction : regHit

	function automatic spc_pkg::spc_state_e modeSelect(input logic pds,
		input logic ppds, input logic dbg, input logic low_voltage_detector);
		if (!pds || dbg || low_voltage_detector) begin
			modeSelect = spc_pkg::ST_STOP3;
		end else if (ppds) begin
			modeSelect = spc_pkg::ST_STOP2;
		end else begin
			modeSelect = spc_pkg::ST_STOP1;
		end
	endfunction : modeSelect

	spc_wake_if wake ();

	spc_wake_sync u_sync (
		.clock     (clock),
		.rstn      (rstn),
		.resetPinN (resetPinN),
		.irqPin    (irqPin),
		.kbiPins   (kbiPins),
		.kbiEnable (kbiEnable),
		.rtiTick   (rtiTick),
		.bgndCmd   (bgndCmd),
		.wake      (wake.src)
	);

	spc_pkg::spc_state_e state_r;
	spc_pkg::spc_state_e state_nxt;
	logic       pds_r;
	logic       ppds_r;
	logic       low_voltage_detect_enable_r;
	logic       lvds_r;
	logic       stopAllow_r;
	logic       dbgAllow_r;
	logic [2:0] rate_r;
	logic       ppdFlag_r;
	logic       dbgEntry_r;
	logic       dbgEntry_nxt;
	logic       lvdEntry_r;
	logic       lvdEntry_nxt;
	logic [1:0] lastVec_r;
	logic       restartNxt;
	logic       illegalNxt;
	logic       intNxt;
	logic [1:0] vecNxt;
	logic       dbgWakeNxt;
	logic       flagSetNxt;
	logic       latchSetNxt;
	logic       ackWrite;
	logic       rtiOn;
	logic       irqLow;
	logic       irqHit;
	logic       inStopNxt;
	logic       deepNxt;

	assign rtiOn    = (rate_r != spc_pkg::RATE_OFF);
	assign irqLow   = ~wake.irqLevel;
	assign irqHit   = irqActiveHigh ? wake.irqLevel : ~wake.irqLevel;
	assign ackWrite = regHit(regAddr, spc_pkg::POWER_MODE_OFS, regWrite)
		&& regWdata[spc_pkg::LATCH_ACK_BIT];

	// ------------------------------------------------------------
	// Mode sequencing
	// ------------------------------------------------------------
	always_comb begin
		state_nxt   = state_r;
		restartNxt  = 1'b0;
		illegalNxt  = 1'b0;
		intNxt      = 1'b0;
		vecNxt      = spc_pkg::VEC_NONE;
		dbgWakeNxt  = 1'b0;
		flagSetNxt  = 1'b0;
		latchSetNxt = 1'b0;
		case (state_r)
			spc_pkg::ST_RUN: begin
				if (stopExec && !stopAllow_r) begin
					illegalNxt = 1'b1;
				end else if (stopExec) begin
					state_nxt = modeSelect(pds_r, ppds_r, dbgAllow_r,
						low_voltage_detect_enable_r && lvds_r);
					latchSetNxt = (state_nxt == spc_pkg::ST_STOP2);
				end
			end
			spc_pkg::ST_STOP1: begin
				if (wake.resetReq || irqLow) begin
					state_nxt = spc_pkg::ST_REARM;
				end
			end
			spc_pkg::ST_REARM: begin
				if (supplyRearm) begin
					state_nxt  = spc_pkg::ST_RUN;
					restartNxt = 1'b1;
				end
			end
			spc_pkg::ST_STOP2: begin
				if (wake.resetReq || irqLow || (wake.rtiEvt && rtiOn)) begin
					state_nxt  = spc_pkg::ST_RUN;
					restartNxt = 1'b1;
					flagSetNxt = 1'b1;
				end
			end
			spc_pkg::ST_STOP3: begin
				if (wake.resetReq) begin
					state_nxt  = spc_pkg::ST_RUN;
					restartNxt = 1'b1;
				end else if (wake.bgndEvt && dbgEntry_r) begin
					state_nxt  = spc_pkg::ST_RUN;
					dbgWakeNxt = 1'b1;
				end else if (irqHit) begin
					state_nxt = spc_pkg::ST_RUN;
					intNxt    = 1'b1;
					vecNxt    = spc_pkg::VEC_IRQ;
				end else if (wake.kbiAny) begin
					state_nxt = spc_pkg::ST_RUN;
					intNxt    = 1'b1;
					vecNxt    = spc_pkg::VEC_KBD;
				end else if (wake.rtiEvt && rtiOn) begin
					state_nxt = spc_pkg::ST_RUN;
					intNxt    = 1'b1;
					vecNxt    = spc_pkg::VEC_TMR;
				end
			end
			default: begin
				state_nxt = spc_pkg::ST_RUN;
			end
		endcase
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			state_r <= spc_pkg::ST_RUN;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Debug and detector options are frozen at the stop instruction
	assign dbgEntry_nxt = (state_r == spc_pkg::ST_RUN && stopExec) ?
		dbgAllow_r : dbgEntry_r;
	assign lvdEntry_nxt = (state_r == spc_pkg::ST_RUN && stopExec) ?
		(low_voltage_detect_enable_r && lvds_r) : lvdEntry_r;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			dbgEntry_r <= 1'b0;
			lvdEntry_r <= 1'b0;
		end else begin
			dbgEntry_r <= dbgEntry_nxt;
			lvdEntry_r <= lvdEntry_nxt;
		end
	end

	// ------------------------------------------------------------
	// Power and clock controls
	// ------------------------------------------------------------
	assign inStopNxt = (state_nxt != spc_pkg::ST_RUN);
	assign deepNxt   = (state_nxt == spc_pkg::ST_STOP1) ||
		(state_nxt == spc_pkg::ST_REARM);

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			sysClockHalt     <= 1'b0;
			oscRun           <= 1'b1;
			debugClockRun    <= 1'b1;
			regulatorStandby <= 1'b0;
			converterStandby <= 1'b0;
			corePowerOn      <= 1'b1;
			ramPowerOn       <= 1'b1;
			pinForceReset    <= 1'b0;
			lowVoltageAssert <= 1'b0;
			wakeTimerOn      <= 1'b0;
		end else begin
			sysClockHalt     <= inStopNxt;
			oscRun           <= !inStopNxt || dbgEntry_nxt;
			debugClockRun    <= !inStopNxt || dbgEntry_nxt;
			regulatorStandby <= inStopNxt &&
				!(dbgEntry_nxt || lvdEntry_nxt);
			converterStandby <= inStopNxt;
			corePowerOn      <= !(deepNxt ||
				state_nxt == spc_pkg::ST_STOP2);
			ramPowerOn       <= !deepNxt;
			pinForceReset    <= deepNxt;
			lowVoltageAssert <= deepNxt;
			wakeTimerOn      <= rtiOn && !deepNxt;
		end
	end

	// ------------------------------------------------------------
	// Pin latches and partial power-down flag
	// ------------------------------------------------------------
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			pinLatchHold <= 1'b0;
			ppdFlag_r    <= 1'b0;
		end else begin
			// Set wins over an acknowledge in the same cycle
			if (latchSetNxt || flagSetNxt) begin
				pinLatchHold <= 1'b1;
			end else if (ackWrite) begin
				pinLatchHold <= 1'b0;
			end
			if (flagSetNxt) begin
				ppdFlag_r <= 1'b1;
			end else if (ackWrite) begin
				ppdFlag_r <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Control registers other than dbgAllow_r, returned to defaults by a power-on restart
	// ------------------------------------------------------------
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			pds_r       <= spc_pkg::CTRL_BIT_RST;
			ppds_r      <= spc_pkg::CTRL_BIT_RST;
			low_voltage_detect_enable_r      <= spc_pkg::CTRL_BIT_RST;
			lvds_r      <= spc_pkg::CTRL_BIT_RST;
			stopAllow_r <= spc_pkg::CTRL_BIT_RST;
			dbgAllow_r  <= spc_pkg::CTRL_BIT_RST;
			rate_r      <= spc_pkg::RATE_OFF;
		end else if (restartNxt) begin
			pds_r       <= spc_pkg::CTRL_BIT_RST;
			ppds_r      <= spc_pkg::CTRL_BIT_RST;
			low_voltage_detect_enable_r      <= spc_pkg::CTRL_BIT_RST;
			lvds_r      <= spc_pkg::CTRL_BIT_RST;
			stopAllow_r <= spc_pkg::CTRL_BIT_RST;
			rate_r      <= spc_pkg::RATE_OFF;
		end else if (regHit(regAddr, spc_pkg::POWER_MODE_OFS, regWrite)) begin
			pds_r  <= regWdata[spc_pkg::PWR_DOWN_BIT];
			ppds_r <= regWdata[spc_pkg::PART_DOWN_BIT];
		end else if (regHit(regAddr, spc_pkg::VOLT_DETECT_OFS,
			regWrite)) begin
			low_voltage_detect_enable_r <= regWdata[spc_pkg::LVD_ENABLE_BIT];
			lvds_r <= regWdata[spc_pkg::LVD_IN_STOP_BIT];
		end else if (regHit(regAddr, spc_pkg::OPTION_OFS, regWrite)) begin
			stopAllow_r <= regWdata[spc_pkg::STOP_ALLOW_BIT];
			dbgAllow_r  <= regWdata[spc_pkg::DEBUG_ALLOW_BIT];
			rate_r      <= regWdata[spc_pkg::RATE_MSB:spc_pkg::RATE_LSB];
		end
	end

	// ------------------------------------------------------------
	// Read port, data valid one cycle after the strobe
	// ------------------------------------------------------------
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			regRdata <= spc_pkg::READ_ZERO;
		end else begin
			regRdata <= spc_pkg::READ_ZERO;
			if (regHit(regAddr, spc_pkg::POWER_MODE_OFS, regRead)) begin
				regRdata[spc_pkg::PWR_DOWN_BIT]  <= pds_r;
				regRdata[spc_pkg::PART_DOWN_BIT] <= ppds_r;
				regRdata[spc_pkg::PART_FLAG_BIT] <= ppdFlag_r;
			end else if (regHit(regAddr, spc_pkg::VOLT_DETECT_OFS,
				regRead)) begin
				regRdata[spc_pkg::LVD_ENABLE_BIT]  <= low_voltage_detect_enable_r;
				regRdata[spc_pkg::LVD_IN_STOP_BIT] <= lvds_r;
			end else if (regHit(regAddr, spc_pkg::OPTION_OFS, regRead)) begin
				regRdata[spc_pkg::STOP_ALLOW_BIT]  <= stopAllow_r;
				regRdata[spc_pkg::DEBUG_ALLOW_BIT] <= dbgAllow_r;
				regRdata[spc_pkg::RATE_MSB:spc_pkg::RATE_LSB] <= rate_r;
			end else if (regHit(regAddr, spc_pkg::STATUS_OFS, regRead)) begin
				regRdata[2:0] <= state_r;
				regRdata[spc_pkg::STAT_VEC_LSB+:2] <= lastVec_r;
			end
		end
	end

	// ------------------------------------------------------------
	// Event pulses and debug command handling
	// ------------------------------------------------------------
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			illegalOpReset <= 1'b0;
			porRestart     <= 1'b0;
			intWake        <= 1'b0;
			intVector      <= spc_pkg::VEC_NONE;
			lastVec_r      <= spc_pkg::VEC_NONE;
			debugWake      <= 1'b0;
			debugStopError <= 1'b0;
			memAccessBlock <= 1'b0;
		end else begin
			illegalOpReset <= illegalNxt;
			porRestart     <= restartNxt;
			intWake        <= intNxt;
			intVector      <= vecNxt;
			if (intNxt) begin
				lastVec_r <= vecNxt;
			end
			debugWake      <= dbgWakeNxt;
			debugStopError <= (state_r != spc_pkg::ST_RUN) &&
				memStatusCmd;
			memAccessBlock <= inStopNxt;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	a_illegal_stop: assert property (@(posedge clock) disable iff (!rstn)
		state_r == spc_pkg::ST_RUN && stopExec && !stopAllow_r |=>
		illegalOpReset && state_r == spc_pkg::ST_RUN)
		else $error("stop without permission did not force reset");
	a_stop_halts: assert property (@(posedge clock) disable iff (!rstn)
		state_r == spc_pkg::ST_RUN && stopExec && stopAllow_r |=>
		sysClockHalt && state_r != spc_pkg::ST_RUN)
		else $error("stop entry did not halt clocks");
	a_mode_light: assert property (@(posedge clock) disable iff (!rstn)
		state_r == spc_pkg::ST_RUN && stopExec && stopAllow_r && !pds_r
		|=> state_r == spc_pkg::ST_STOP3)
		else $error("power-down clear did not select stop3");
	a_debug_stop3: assert property (@(posedge clock) disable iff (!rstn)
		state_r == spc_pkg::ST_RUN && stopExec && stopAllow_r && dbgAllow_r
		|=> state_r == spc_pkg::ST_STOP3 ##1 debugClockRun)
		else $error("debug allowed but deep stop entered");
	a_debug_osc: assert property (@(posedge clock) disable iff (!rstn)
		state_r == spc_pkg::ST_STOP3 && dbgEntry_r |->
		oscRun && !regulatorStandby)
		else $error("debug stop lost oscillator or regulation");
	a_lvd_stop3: assert property (@(posedge clock) disable iff (!rstn)
		state_r == spc_pkg::ST_RUN && stopExec && stopAllow_r && low_voltage_detect_enable_r &&
		lvds_r |=> state_r == spc_pkg::ST_STOP3 && !regulatorStandby)
		else $error("detector in stop did not force stop3");
	a_stop1_power: assert property (@(posedge clock) disable iff (!rstn)
		state_r == spc_pkg::ST_STOP1 |-> !corePowerOn && !ramPowerOn &&
		pinForceReset && !wakeTimerOn && lowVoltageAssert)
		else $error("stop1 power controls wrong");
	a_stop1_rearm: assert property (@(posedge clock) disable iff (!rstn)
		state_r == spc_pkg::ST_REARM && !supplyRearm |=>
		!porRestart && state_r == spc_pkg::ST_REARM)
		else $error("stop1 left before supply rearm");
	a_stop2_flag: assert property (@(posedge clock) disable iff (!rstn)
		state_r == spc_pkg::ST_STOP2 && state_nxt == spc_pkg::ST_RUN |=>
		ppdFlag_r && porRestart && pinLatchHold)
		else $error("stop2 wake did not set flag and keep latches");
	a_latch_release: assert property (@(posedge clock) disable iff (!rstn)
		state_r == spc_pkg::ST_RUN && ackWrite && !stopExec |=>
		!pinLatchHold && !ppdFlag_r)
		else $error("acknowledge did not release latches");
	a_timer_off: assert property (@(posedge clock) disable iff (!rstn)
		rate_r == spc_pkg::RATE_OFF |=> !wakeTimerOn)
		else $error("wake timer running with rate zero");

endmodule : spc_stop_ctrl

`default_nettype wire

/* verif/spc_far_model.sv */
// Far-side model: CPU stop pulse, wake pins, wake-timer tick and supply.
// Assumes the bench issues one command code per cycle, zero when idle.

`timescale 1ns/1ps
`default_nettype none

module spc_far_model (
	input  wire logic       clock,
	input  wire logic [2:0] cmd,
	input  wire logic       lowVoltageAssert,
	output logic            stopExec,
	output logic            resetPinN,
	output logic            irqPin,
	output logic      [7:0] kbiPins,
	output logic            rtiTick,
	output logic            bgndCmd,
	output logic            supplyRearm
);
	logic [2:0] irqCnt = 3'h0;
	logic [2:0] kbiCnt = 3'h0;
	logic       lvPrev = 1'b0;

	// Pins are driven low to request a wake, held four cycles
	assign irqPin    = (irqCnt == 3'h0);
	assign kbiPins   = {7'h7F, kbiCnt == 3'h0};

	initial begin
		resetPinN   = 1'b1;
		stopExec    = 1'b0;
		rtiTick     = 1'b0;
		bgndCmd     = 1'b0;
		supplyRearm = 1'b1;
	end

	always @(posedge clock) begin
		stopExec <= (cmd == 3'h1);
		resetPinN <= (cmd != 3'h7);
		rtiTick  <= (cmd == 3'h4);
		bgndCmd  <= (cmd == 3'h5);
		irqCnt   <= (cmd == 3'h2) ? 3'h4 : irqCnt - {2'h0, irqCnt != 3'h0};
		kbiCnt   <= (cmd == 3'h3) ? 3'h4 : kbiCnt - {2'h0, kbiCnt != 3'h0};
		lvPrev   <= lowVoltageAssert;
		// Supply sags when the low-voltage condition is raised
		if (cmd == 3'h6)
			supplyRearm <= 1'b1;
		else if (lowVoltageAssert && !lvPrev)
			supplyRearm <= 1'b0;
	end
endmodule : spc_far_model

`default_nettype wire

/* verif/tb_spc_stop_ctrl.sv */
// Bench for the stop-mode controller: mode choice, power outputs, wake
// paths, pin latch release, debug and low-voltage overrides.
// Assumes spc_far_model for the CPU, wake pins and supply.

`timescale 1ns/1ps
`default_nettype none

module tb_spc_stop_ctrl;
	logic       clock, rstn, regWrite, regRead, memStatusCmd, clrSeen;
	logic       irqHigh;
	logic [3:0] regAddr;
	logic [7:0] regWdata, regRdata, kbiPins, pw;
	logic [2:0] cmd;
	logic       stopExec, resetPinN, irqPin, rtiTick, bgndCmd, supplyRearm;
	logic       sysClockHalt, oscRun, debugClockRun, regulatorStandby;
	logic       converterStandby, corePowerOn, ramPowerOn, pinForceReset;
	logic       pinLatchHold, wakeTimerOn, lowVoltageAssert, illegalOpReset;
	logic       porRestart, intWake, debugWake, debugStopError, memAccessBlock;
	logic [1:0] intVector, vecSeen;
	logic       porSeen, intSeen, illSeen, dwSeen, errSeen;
	int         errors, comparisons, cycles;

	assign pw = {sysClockHalt, oscRun, regulatorStandby, corePowerOn,
		ramPowerOn, pinLatchHold, pinForceReset, wakeTimerOn};

	spc_far_model far (.clock(clock), .cmd(cmd),
		.lowVoltageAssert(lowVoltageAssert), .stopExec(stopExec),
		.resetPinN(resetPinN), .irqPin(irqPin), .kbiPins(kbiPins),
		.rtiTick(rtiTick), .bgndCmd(bgndCmd), .supplyRearm(supplyRearm));

	spc_stop_ctrl dut (.clock(clock), .rstn(rstn), .regAddr(regAddr),
		.regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
		.regRdata(regRdata), .stopExec(stopExec), .resetPinN(resetPinN),
		.irqPin(irqPin), .irqActiveHigh(irqHigh), .kbiPins(kbiPins),
		.kbiEnable(8'hFF), .rtiTick(rtiTick), .bgndCmd(bgndCmd),
		.memStatusCmd(memStatusCmd), .supplyRearm(supplyRearm),
		.sysClockHalt(sysClockHalt), .oscRun(oscRun),
		.debugClockRun(debugClockRun), .regulatorStandby(regulatorStandby),
		.converterStandby(converterStandby), .corePowerOn(corePowerOn),
		.ramPowerOn(ramPowerOn), .pinForceReset(pinForceReset),
		.pinLatchHold(pinLatchHold), .wakeTimerOn(wakeTimerOn),
		.lowVoltageAssert(lowVoltageAssert), .illegalOpReset(illegalOpReset),
		.porRestart(porRestart), .intWake(intWake), .intVector(intVector),
		.debugWake(debugWake), .debugStopError(debugStopError),
		.memAccessBlock(memAccessBlock));

	// ------------------------------------------------------------
	// Pulse capture and run limit
	// ------------------------------------------------------------
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (clrSeen)
			{porSeen, intSeen, illSeen, dwSeen, errSeen, vecSeen} <= '0;
		else begin
			porSeen <= porSeen | porRestart;
			intSeen <= intSeen | intWake;
			illSeen <= illSeen | illegalOpReset;
			dwSeen  <= dwSeen | debugWake;
			errSeen <= errSeen | debugStopError;
			if (intWake)
				vecSeen <= intVector;
		end
		if (cycles == 5000) begin
			errors++;
			report_and_stop();
		end
	end

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock);
		regAddr  <= a;
		regWdata <= d;
		regWrite <= 1'b1;
		@(posedge clock);
		regWrite <= 1'b0;
	endtask : wr

	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clock);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clock);
		regRead <= 1'b0;
		#1 chk(regRdata, exp);
	endtask : rd

	// Issue one far-side command, then let n cycles pass
	task automatic go(input logic [2:0] c, input int n);
		@(posedge clock);
		clrSeen <= 1'b1;
		cmd     <= c;
		@(posedge clock);
		clrSeen <= 1'b0;
		cmd     <= 3'h0;
		repeat (n) @(posedge clock);
		#1;
	endtask : go

	task automatic report_and_stop();
		$display("errors=%0d comparisons=%0d", errors, comparisons);
		if (errors == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : report_and_stop

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_reset_illegal();
		chk(pw, 8'h58);
		rd(4'h2, 8'h00);
		rd(4'h9, 8'h00);
		go(3'h1, 3);
		chk({7'h0, illSeen}, 8'h01);
		chk(pw, 8'h58);
	endtask : t_reset_illegal

	task automatic t_stop3();
		logic [1:0] v;
		wr(4'h0, 8'h00);
		wr(4'h2, 8'h05);
		for (int i = 0; i < 3; i++) begin
			v = 2'(i + 1);
			go(3'h1, 3);
			chk(pw, 8'hB9);
			chk({7'h0, converterStandby}, 8'h01);
			rd(4'h3, {3'h0, 2'(i), 3'h3});
			go(3'(i + 2), 8);
			chk({5'h0, intSeen, vecSeen}, {5'h1, v});
			rd(4'h3, {3'h0, v, 3'h0});
		end
		go(3'h1, 3);
		go(3'h7, 8);
		chk({5'h0, porSeen, intSeen, sysClockHalt}, 8'h04);
	endtask : t_stop3

	task automatic t_stop2();
		wr(4'h0, 8'h03);
		wr(4'h2, 8'h05);
		irqHigh <= 1'b1;
		go(3'h1, 3);
		chk(pw, 8'hAD);
		rd(4'h3, 8'h1A);
		go(3'h2, 8);
		chk({6'h0, porSeen, intSeen}, 8'h02);
		chk(pw, 8'h5C);
		rd(4'h2, 8'h00);
		rd(4'h0, 8'h08);
		wr(4'h0, 8'h04);
		rd(4'h0, 8'h00);
		chk(pw, 8'h58);
	endtask : t_stop2

	task automatic t_stop1();
		wr(4'h0, 8'h01);
		wr(4'h2, 8'h05);
		go(3'h1, 3);
		chk(pw, 8'hA2);
		chk({7'h0, lowVoltageAssert}, 8'h01);
		go(3'h4, 8);
		chk({6'h0, porSeen, intSeen}, 8'h00);
		go(3'h2, 8);
		rd(4'h3, 8'h1C);
		chk({7'h0, porSeen}, 8'h00);
		go(3'h6, 6);
		chk({7'h0, porSeen}, 8'h01);
		chk(pw, 8'h58);
	endtask : t_stop1

	task automatic t_debug_lvd();
		wr(4'h0, 8'h03);
		wr(4'h2, 8'h03);
		irqHigh <= 1'b0;
		go(3'h1, 3);
		rd(4'h3, 8'h1B);
		chk({pw[7:1], debugClockRun}, 8'hD9);
		@(posedge clock);
		memStatusCmd <= 1'b1;
		@(posedge clock);
		memStatusCmd <= 1'b0;
		repeat (3) @(posedge clock);
		#1;
		chk({6'h0, errSeen, memAccessBlock}, 8'h03);
		go(3'h4, 8);
		chk({6'h0, intSeen, sysClockHalt}, 8'h01);
		go(3'h5, 8);
		chk({6'h0, dwSeen, sysClockHalt}, 8'h02);
		wr(4'h2, 8'h00);
		wr(4'h1, 8'h03);
		wr(4'h0, 8'h01);
		wr(4'h2, 8'h01);
		go(3'h1, 3);
		rd(4'h3, 8'h1B);
		chk(pw, 8'h98);
		go(3'h3, 8);
		chk({5'h0, intSeen, vecSeen}, 8'h06);
		wr(4'h1, 8'h00);
	endtask : t_debug_lvd

	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end

	initial begin
		{rstn, regWrite, regRead, memStatusCmd, clrSeen, irqHigh} = '0;
		regAddr     = 4'h0;
		regWdata    = 8'h00;
		cmd         = 3'h0;
		errors      = 0;
		comparisons = 0;
		cycles      = 0;
		repeat (20) @(posedge clock);
		rstn <= 1'b1;
		@(posedge clock);
		#1;
		t_reset_illegal();
		t_stop3();
		t_stop2();
		t_stop1();
		t_debug_lvd();
		report_and_stop();
	end
endmodule : tb_spc_stop_ctrl

`default_nettype wire
